// ===== core/ctm_pkg.sv
// Package: register map, field positions and constants for the compact timer
package ctm_pkg;
  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTM_OFF_CTRL0  = 8'h00;
  localparam logic [7:0] CTM_OFF_CTRL1  = 8'h04;
  localparam logic [7:0] CTM_OFF_COUNT  = 8'h08;
  localparam logic [7:0] CTM_OFF_CMPA   = 8'h0C;
  localparam logic [7:0] CTM_OFF_CMPP   = 8'h10;
  localparam logic [7:0] CTM_OFF_FLAGS  = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTM_ON_BIT      = 3;
  localparam int CTM_MODE_HI     = 7;
  localparam int CTM_MODE_LO     = 6;
  localparam int CTM_IO_HI       = 5;
  localparam int CTM_IO_LO       = 4;
  localparam int CTM_OC_BIT      = 3;
  localparam int CTM_POL_BIT     = 2;
  localparam int CTM_DPX_BIT     = 1;
  localparam int CTM_CCLR_BIT    = 0;
  localparam int CTM_FLAG_A_BIT  = 0;
  localparam int CTM_FLAG_P_BIT  = 1;

  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          CTM_CNT_W     = 10;
  localparam logic [7:0]  CTM_CTRL_RST  = 8'h00;
  localparam logic [9:0]  CTM_CMP_RST   = 10'h000;
  localparam logic [9:0]  CTM_CNT_MAX   = 10'h3FF;
  localparam logic [2:0]  CTM_CMPP_RST  = 3'h0;

  // Mode field encodings
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'b00,
    CTM_MODE_RSV = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TMR = 2'b11
  } ctm_mode_t;

  // Output function encodings
  localparam logic [1:0] CTM_IO_NONE   = 2'b00;
  localparam logic [1:0] CTM_IO_LOW    = 2'b01;
  localparam logic [1:0] CTM_IO_HIGH   = 2'b10;
  localparam logic [1:0] CTM_IO_TOGGLE = 2'b11;
  localparam logic [1:0] CTM_PWM_INACT = 2'b00;
  localparam logic [1:0] CTM_PWM_ACT   = 2'b01;
  localparam logic [1:0] CTM_PWM_WAVE  = 2'b10;

  // Bus transfer state, one-hot
  typedef enum logic [1:0] {
    CTM_BUS_IDLE = 2'b01,
    CTM_BUS_DATA = 2'b10
  } ctm_bus_t;
endpackage : ctm_pkg

// ===== core/ctm_timer.sv
// Compact 10-bit timer with compare, timer/counter and PWM modes, AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
module ctm_timer
  import ctm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        count_tick,
  output logic             timer_out,
  output logic             timer_out_en,
  output logic             compare_a_match_flag,
  output logic             period_match_flag
);
  import ctm_pkg::*;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Word map seen by software; fields sit in the low bits, the rest read zero:
  //   CTRL0  bit 3 on bit; a low-to-high change restarts the counter
  //   CTRL1  7:6 mode, 5:4 output function, 3 initial or active level,
  //          2 polarity, 1 period/duty swap, 0 clear select
  //   COUNT  10-bit counter, read only
  //   CMPA   10-bit compare A value
  //   CMPP   3-bit period code, compared against counter bits 9..7
  //   FLAGS  bit 0 compare A match, bit 1 period match; write 1 to clear
  // Mode, output function and swap should change only while stopped: a
  // change while running acts at once and may cut a PWM period short.
  logic              timer_on_bit;
  logic [7:0]        compact_timer_control_one;
  logic [9:0]        compare_a_value;
  logic [2:0]        period_compare_value;
  logic [9:0]        count;
  logic              on_prev;
  logic              pin_level;
  logic              pwm_active;
  ctm_bus_t          bus_state;
  logic [7:0]        wr_addr;
  logic              wr_pend;

  // Control field views
  // Names for the control byte's fields; they change only when software writes
  ctm_mode_t         mode;
  logic [1:0]        output_function;
  logic              output_initial_level;
  logic              output_polarity_invert;
  logic              period_duty_swap;
  logic              counter_clear_select;

  assign mode                   = ctm_mode_t'(compact_timer_control_one[CTM_MODE_HI:CTM_MODE_LO]);
  assign output_function        = compact_timer_control_one[CTM_IO_HI:CTM_IO_LO];
  assign output_initial_level   = compact_timer_control_one[CTM_OC_BIT];
  assign output_polarity_invert = compact_timer_control_one[CTM_POL_BIT];
  assign period_duty_swap       = compact_timer_control_one[CTM_DPX_BIT];
  assign counter_clear_select   = compact_timer_control_one[CTM_CCLR_BIT];

  // ---------------------------------------------------------------------------
  // Bus slave: one wait-free data phase, always OKAY
  // ---------------------------------------------------------------------------
  logic take;
  logic bus_wr;

  // Only NONSEQ or SEQ with the bus ready opens a transfer; IDLE and BUSY
  // are ignored, and hsize is not checked since every register is one word.
  // No transfer ever waits, so hreadyout stays high
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_wr    = wr_pend;

  // Address phase capture; the write itself lands one cycle later,
  // when hwdata stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= CTM_BUS_IDLE;
      wr_addr   <= 8'h00;
      wr_pend   <= 1'b0;
    end else begin
      wr_pend <= take && hwrite;
      if (take) begin
        wr_addr   <= haddr[7:0];
        bus_state <= CTM_BUS_DATA;
      end else begin
        bus_state <= CTM_BUS_IDLE;
      end
    end
  end

  // Read data registered at the address phase
  // Unmapped offsets read as zero; a write leaves hrdata untouched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        CTM_OFF_CTRL0: hrdata <= {28'h0000000, timer_on_bit, 3'h0};
        CTM_OFF_CTRL1: hrdata <= {24'h000000, compact_timer_control_one};
        CTM_OFF_COUNT: hrdata <= {22'h000000, count};
        CTM_OFF_CMPA:  hrdata <= {22'h000000, compare_a_value};
        CTM_OFF_CMPP:  hrdata <= {29'h00000000, period_compare_value};
        CTM_OFF_FLAGS: hrdata <= {30'h00000000, period_match_flag, compare_a_match_flag};
        default:       hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software-written registers
  // Writes land in the data phase, one cycle after the address was taken;
  // bits above each field are dropped and no error response is ever given
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_on_bit              <= 1'b0;
      compact_timer_control_one <= CTM_CTRL_RST;
      compare_a_value           <= CTM_CMP_RST;
      period_compare_value      <= CTM_CMPP_RST;
    end else if (bus_wr && bus_state == CTM_BUS_DATA) begin
      case (wr_addr)
        CTM_OFF_CTRL0: timer_on_bit              <= hwdata[CTM_ON_BIT];
        CTM_OFF_CTRL1: compact_timer_control_one <= hwdata[7:0];
        CTM_OFF_CMPA:  compare_a_value           <= hwdata[9:0];
        CTM_OFF_CMPP:  period_compare_value      <= hwdata[2:0];
        default:       ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Comparators and clear selection
  // ---------------------------------------------------------------------------
  logic       on_rise;
  logic       at_max;
  logic       match_a;
  logic       match_p;
  logic       clear_now;
  logic       is_pwm;
  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic [10:0] code_len;
  logic [10:0] a_len;

  // Start edge, mode decode and the top-count detector
  assign on_rise = timer_on_bit && !on_prev;
  assign is_pwm  = (mode == CTM_MODE_PWM);
  assign at_max  = (count == CTM_CNT_MAX);

  // Period match on the last count before code times 128, so that the
  // clear makes the period exactly that many counts; code zero matches
  // only at the full-count wrap
  assign match_p = timer_on_bit && count_tick && (period_compare_value == CTM_CMPP_RST ? at_max
                   : (count[9:7] == period_compare_value - 3'h1 && count[6:0] == 7'h7F));
  // Compare A matches the same way, one count early; a zero value never matches
  assign match_a = timer_on_bit && count_tick && (compare_a_value == CTM_CMP_RST ? 1'b0
                   : (count == compare_a_value - 10'h001));

  // Lengths in counts, code zero meaning 1024
  // Lengths are 11 bits wide so that 1024 fits; the swap bit decides which
  // of the two is the period
  assign code_len = {(period_compare_value == CTM_CMPP_RST), period_compare_value, 7'h00};
  assign a_len    = {1'b0, compare_a_value};
  assign period_len = period_duty_swap ? a_len : code_len;
  assign duty_len   = period_duty_swap ? code_len : a_len;

  // Clear source: swap bit in PWM, clear select elsewhere
  // The counter also wraps at its top value whatever the source
  always_comb begin
    if (is_pwm) begin
      clear_now = period_duty_swap ? match_a : match_p;
    end else if (counter_clear_select) begin
      clear_now = match_a;
    end else begin
      clear_now = match_p;
    end
    if (timer_on_bit && count_tick && at_max) begin
      clear_now = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // Previous on bit for the start edge; it resets to the off level so that
  // no false start follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_prev <= 1'b0;
    end else begin
      on_prev <= timer_on_bit;
    end
  end

  // Count up on each tick; a start or a clear returns to zero, and a stop
  // holds the value for software to read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 10'h000;
    end else begin
      if (on_rise) begin
        count <= 10'h000;
      end else if (clear_now) begin
        count <= 10'h000;
      end else if (timer_on_bit && count_tick) begin
        count <= count + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Match flags, sticky; set wins over a software clear
  // ---------------------------------------------------------------------------
  logic clr_a;
  logic clr_p;

  assign clr_a = bus_wr && wr_addr == CTM_OFF_FLAGS && hwdata[CTM_FLAG_A_BIT];
  assign clr_p = bus_wr && wr_addr == CTM_OFF_FLAGS && hwdata[CTM_FLAG_P_BIT];

  // Compare A flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_a_match_flag <= 1'b0;
    end else if (match_a) begin
      compare_a_match_flag <= 1'b1;
    end else if (clr_a) begin
      compare_a_match_flag <= 1'b0;
    end
  end

  // Period flag; outside PWM it stays low while compare A clears the counter,
  // even when the period code lies below the compare A value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_match_flag <= 1'b0;
    end else if (match_p && (is_pwm || !counter_clear_select)) begin
      period_match_flag <= 1'b1;
    end else if (clr_p) begin
      period_match_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Compare output pin level
  // ---------------------------------------------------------------------------
  // Only a compare A match moves the pin, and only in compare mode; the
  // start edge wins over a match in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_level <= 1'b0;
    end else if (on_rise) begin
      pin_level <= output_initial_level;
    end else if (match_a && mode == CTM_MODE_CMP) begin
      case (output_function)
        CTM_IO_LOW:    pin_level <= 1'b0;
        CTM_IO_HIGH:   pin_level <= 1'b1;
        CTM_IO_TOGGLE: pin_level <= !pin_level;
        default:       pin_level <= pin_level;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // PWM waveform and output stage
  // ---------------------------------------------------------------------------
  // Active while the count is below the duty length; the compare is
  // registered, so the pin trails the counter by two cycles, and it keeps
  // running under a forced level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_active <= 1'b0;
    end else begin
      // Duty at or above period stays active the whole period
      pwm_active <= (duty_len >= period_len) || ({1'b0, count} < duty_len);
    end
  end

  logic raw_out;

  // Output function picks the waveform or a forced level in PWM mode;
  // code 11 is undefined and is treated as inactive
  always_comb begin
    raw_out = pin_level;
    if (is_pwm) begin
      case (output_function)
        CTM_PWM_INACT: raw_out = !output_initial_level;
        CTM_PWM_ACT:   raw_out = output_initial_level;
        CTM_PWM_WAVE:  raw_out = pwm_active ? output_initial_level : !output_initial_level;
        default:       raw_out = !output_initial_level;
      endcase
    end
  end

  // Registered pin, polarity applied last so that the inversion also
  // covers the forced levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_out <= 1'b0;
    end else begin
      timer_out <= raw_out ^ output_polarity_invert;
    end
  end

  // Pin enable: compare and PWM modes drive the pin, timer/counter mode and
  // the unused mode code leave it free for other functions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_out_en <= 1'b0;
    end else begin
      timer_out_en <= (mode == CTM_MODE_CMP) || is_pwm;
    end
  end

endmodule // ctm_timer
`default_nettype wire

// ===== testbench/ctm_timer_checker.sv
// Checker for the compact timer pin, enable and flag behaviour
`timescale 1ns/10ps
`default_nettype none
module ctm_timer_checker
  import ctm_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        timer_out,
  input wire logic        timer_out_en,
  input wire logic        compare_a_match_flag,
  input wire logic        period_match_flag
);
  logic        wr_q;
  logic [7:0]  a_q;
  logic [7:0]  ctl;
  logic        on;
  logic [9:0]  cmpa;
  logic [2:0]  code;
  logic [10:0] plen;
  logic        clr_a;
  logic        clr_p;
  logic        pwm;
  // ---------------------------------------------------------------------------
  // Shadow of the software settings
  // ---------------------------------------------------------------------------
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      a_q  <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel & htrans[1] & hwrite;
      a_q  <= haddr[7:0];
    end
  end
  // Data phase lands in the shadow copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl  <= 8'h00;
      on   <= 1'b0;
      cmpa <= 10'h000;
      code <= 3'h0;
    end else if (wr_q && hready) begin
      if (a_q == CTM_OFF_CTRL0) on <= hwdata[CTM_ON_BIT];
      if (a_q == CTM_OFF_CTRL1) ctl <= hwdata[7:0];
      if (a_q == CTM_OFF_CMPA) cmpa <= hwdata[9:0];
      if (a_q == CTM_OFF_CMPP) code <= hwdata[2:0];
    end
  end
  // Period length and clear strobes
  assign plen  = (code == 3'h0) ? 11'h400 : {1'b0, code, 7'h00};
  assign clr_a = wr_q && (a_q == CTM_OFF_FLAGS) && hwdata[CTM_FLAG_A_BIT];
  assign clr_p = wr_q && (a_q == CTM_OFF_FLAGS) && hwdata[CTM_FLAG_P_BIT];
  assign pwm   = on && (ctl[7:6] == CTM_MODE_PWM);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_flag_a_hold: assert property ($fell(compare_a_match_flag) |-> $past(clr_a))
    else $error("compare flag dropped without a clear");
  a_flag_p_hold: assert property ($fell(period_match_flag) |-> $past(clr_p))
    else $error("period flag dropped without a clear");
  a_pin_restore: assert property ($rose(on) && ctl[7:6] == CTM_MODE_CMP
    |-> ##2 timer_out == (ctl[CTM_OC_BIT] ^ ctl[CTM_POL_BIT]))
    else $error("pin not at initial level after start");
  a_tmr_pin_free: assert property ((ctl[7:6] == CTM_MODE_TMR) [*2] |-> !timer_out_en)
    else $error("pin driven in timer mode");
  a_cmp_pin_used: assert property ((ctl[7:6] == CTM_MODE_CMP) [*3] |-> timer_out_en)
    else $error("pin not driven in compare mode");
  a_no_period_flag: assert property ((on && ctl[CTM_CCLR_BIT] && !ctl[7]) [*2] |-> !$rose(period_match_flag))
    else $error("period flag raised with compare A clearing");
  a_force_inact: assert property ((pwm && ctl[5:4] == CTM_PWM_INACT) [*3]
    |-> timer_out == (!ctl[CTM_OC_BIT] ^ ctl[CTM_POL_BIT]))
    else $error("forced inactive level wrong");
  a_force_act: assert property ((pwm && ctl[5:4] == CTM_PWM_ACT) [*3]
    |-> timer_out == (ctl[CTM_OC_BIT] ^ ctl[CTM_POL_BIT]))
    else $error("forced active level wrong");
  a_full_duty: assert property ((pwm && ctl[5:4] == CTM_PWM_WAVE && !ctl[CTM_DPX_BIT] && {1'b0, cmpa} >= plen) [*3]
    |-> timer_out == (ctl[CTM_OC_BIT] ^ ctl[CTM_POL_BIT]))
    else $error("full duty output not held active");
endmodule // ctm_timer_checker
bind ctm_timer ctm_timer_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .timer_out(timer_out),
  .timer_out_en(timer_out_en), .compare_a_match_flag(compare_a_match_flag), .period_match_flag(period_match_flag));
`default_nettype wire

// ===== testbench/tb_top.sv
// Testbench for the compact timer over its AHB-Lite register port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import ctm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, tick, t_out, t_en, fa, fp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [10:0] h;
  int n_errors, total_checks;
  logic [7:0]  pc [7] = '{8'hA9, 8'hAD, 8'hA1, 8'hAA, 8'hA8, 8'h88, 8'h98};
  logic [9:0]  pa [7] = '{10'h020, 10'h020, 10'h020, 10'h0C8, 10'h0C8, 10'h020, 10'h020};
  logic [10:0] pn [7] = '{11'd128, 11'd128, 11'd128, 11'd200, 11'd128, 11'd128, 11'd128};
  logic [10:0] pe [7] = '{11'd32, 11'd96, 11'd96, 11'd128, 11'd128, 11'd0, 11'd128};
  // Flags after one window; a compare A value past the period never matches
  logic [1:0]  pf [7] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h3};
  ctm_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .count_tick(tick), .timer_out(t_out), .timer_out_en(t_en),
    .compare_a_match_flag(fa), .period_match_flag(fp));
  // Clock of 4 ns
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ---------------------------------------------------------------------------
  // Bus and helper tasks
  // ---------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, v);
    `CHK(v, e)
    `CHK(hresp, 1'b0)
  endtask
  // Reprogram only with the timer stopped, then clear flags and start
  task automatic cfg(input logic [7:0] c, input logic [9:0] a, input logic [2:0] p);
    wr(CTM_OFF_CTRL0, 32'h0);
    wr(CTM_OFF_CTRL1, {24'h0, c});
    wr(CTM_OFF_CMPA, {22'h0, a});
    wr(CTM_OFF_CMPP, {29'h0, p});
    wr(CTM_OFF_FLAGS, 32'h3);
    wr(CTM_OFF_CTRL0, 32'h8);
  endtask
  task automatic high(input logic [10:0] n);
    h = 11'd0;
    repeat (n) begin
      @(posedge hclk);
      h = h + {10'h0, t_out};
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    test_done();
  end
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; tick = 1'b1; n_errors = 0; total_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (pe[i]) if (i < 6) rd_chk(8'(i * 4), 32'h0);
    rd_chk(8'h40, 32'h0);
    cfg(8'h00, 10'h032, 3'h1);
    repeat (300) @(posedge hclk);
    rd_chk(CTM_OFF_FLAGS, 32'h3);
    bus(1'b0, CTM_OFF_COUNT, 32'h0, v);
    `CHK(v[9:0] < 10'd128, 1'b1)
    wr(CTM_OFF_CTRL0, 32'h0);
    wr(CTM_OFF_FLAGS, 32'h3);
    rd_chk(CTM_OFF_FLAGS, 32'h0);
    cfg(8'h01, 10'h03C, 3'h1);
    repeat (300) @(posedge hclk);
    rd_chk(CTM_OFF_FLAGS, 32'h1);
    bus(1'b0, CTM_OFF_COUNT, 32'h0, v);
    `CHK(v[9:0] < 10'd60, 1'b1)
    cfg(8'h00, 10'h000, 3'h0);
    repeat (1100) @(posedge hclk);
    rd_chk(CTM_OFF_FLAGS, 32'h2);
    cfg(8'hC0, 10'h032, 3'h1);
    repeat (300) @(posedge hclk);
    `CHK(t_en, 1'b0)
    rd_chk(CTM_OFF_FLAGS, 32'h3);
    for (int k = 0; k < 3; k++) begin
      cfg((k < 2) ? 8'h18 : 8'h34, 10'h028, 3'h0);
      repeat (5) @(posedge hclk);
      `CHK({t_en, t_out}, 2'b11)
      repeat (60) @(posedge hclk);
      `CHK(t_out, 1'b0)
    end
    foreach (pc[i]) begin
      cfg(pc[i], pa[i], 3'h1);
      repeat (10) @(posedge hclk);
      high(pn[i]);
      `CHK(h, pe[i])
      rd_chk(CTM_OFF_FLAGS, {30'h0, pf[i]});
      `CHK({fp, fa}, pf[i])
    end
    test_done();
  end
endmodule // tb_top
`default_nettype wire
